// File: logic/ordering_pkg.sv
// Purpose: shared types and constants for the memory ordering enforcer
// Assumes: one hart, in-order issue into a small tracking window
// Notes:   registers are numbered 0..31; register 0 never carries anything
package ordering_pkg;

    localparam int NREG      = 32;
    localparam int REG_W     = 5;
    localparam int WIN       = 8;
    localparam int TAG_W     = 3;
    localparam logic [WIN-1:0] WIN_EMPTY = 8'h00;
    localparam logic [REG_W-1:0] REG_ZERO = 5'h00;

    typedef enum logic [2:0] {
        OP_ALU,
        OP_LOAD,
        OP_STORE,
        OP_AMO,
        OP_FENCE,
        OP_BRANCH,
        OP_JALR
    } op_kind_t;

    // Instruction handed to the enforcer at issue
    typedef struct packed {
        op_kind_t         kind;
        logic [REG_W-1:0] rd;
        logic [REG_W-1:0] rs1;
        logic [REG_W-1:0] rs2;
        logic             aq;
        logic             rl;
        logic             sc_ann;
        logic             is_lr;
        logic             is_sc;
        logic             fence_pr;
        logic             fence_pw;
        logic             fence_sr;
        logic             fence_sw;
    } issue_t;

    // One outstanding memory operation in the window
    typedef struct packed {
        logic is_load;
        logic is_store;
        logic acq;
        logic rel;
        logic rcsc;
        logic lr;
    } entry_t;

endpackage

// File: logic/dep_table.sv
// Purpose: per-register dependency masks, one bit per window slot
// Assumes: one write port, two read ports, register 0 reads as empty
// Notes:   read data come out of a register, so reads lag one cycle
`timescale 1ns/1ps
module dep_table
    import ordering_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Write port
    input  wire logic             we,
    input  wire logic [REG_W-1:0] waddr,
    input  wire logic [WIN-1:0]   wdata,
    // Slot retire clears that bit everywhere
    input  wire logic [WIN-1:0]   clr_mask,
    // Read ports
    input  wire logic [REG_W-1:0] raddr_a,
    input  wire logic [REG_W-1:0] raddr_b,
    output logic      [WIN-1:0]   rdata_a,
    output logic      [WIN-1:0]   rdata_b
);

    logic [WIN-1:0] mem      [NREG];
    logic [WIN-1:0] next_mem [NREG];
    logic [WIN-1:0] next_rdata_a;
    logic [WIN-1:0] next_rdata_b;

    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            next_mem[i] = mem[i] & ~clr_mask;
        end
        if (we && waddr != REG_ZERO) begin
            next_mem[waddr] = wdata & ~clr_mask;
        end
        next_rdata_a = next_mem[raddr_a];
        next_rdata_b = next_mem[raddr_b];
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NREG; i++) begin
                mem[i] <= WIN_EMPTY;
            end
            rdata_a <= WIN_EMPTY;
            rdata_b <= WIN_EMPTY;
        end else begin
            mem     <= next_mem;
            rdata_a <= next_rdata_a;
            rdata_b <= next_rdata_b;
        end
    end

endmodule

// File: logic/hart_memory_ordering_enforcer.sv
// Purpose: decide which issued memory ops each new op must wait behind
// Assumes: memory ops occupy window slots until the memory side retires
// Notes:   output wait_mask names slots that must perform first
// Function
// - Acquire AMO precedes all later accesses
// - Acquire orders only the annotated operation
// - Fence R,RW orders earlier loads before later
// - Release follows all earlier loads and stores
// - Fence RW,W orders earlier accesses before stores
// - Release-to-acquire ordered only when both RCsc
// - Store-conditional follows its paired load-reserved
// - Address dependency on load orders after load
// - Data dependency orders after earlier operation
// - Store after dependent branch orders after source
// - Destination inherits all source register dependencies
// - Load destination starts a fresh dependency
// - Indirect jump link carries no dependency
`timescale 1ns/1ps
module hart_memory_ordering_enforcer
    import ordering_pkg::*;
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           nrst,
    // Issue side
    input  wire logic           issue_valid,
    input  wire issue_t         issue,
    output logic                issue_ready,
    // Ordering answer for the op just issued
    output logic                ord_valid,
    output logic [TAG_W-1:0]    ord_slot,
    output logic [WIN-1:0]      ord_wait_mask,
    // Memory side retires performed slots
    input  wire logic [WIN-1:0] perform_done,
    // Window occupancy
    output logic [WIN-1:0]      busy
);

    // Window state
    entry_t         win      [WIN];
    entry_t         next_win [WIN];
    logic [WIN-1:0] next_busy;
    // Masks carried forward by fences, acquires and branches
    logic [WIN-1:0] acq_block;        // waits every later access
    logic [WIN-1:0] ld_block;         // waits every later access
    logic [WIN-1:0] st_block;         // waits later stores only
    logic [WIN-1:0] ctrl_block;       // waits later stores only
    logic [WIN-1:0] next_acq_block;
    logic [WIN-1:0] next_ld_block;
    logic [WIN-1:0] next_st_block;
    logic [WIN-1:0] next_ctrl_block;
    logic [TAG_W-1:0] lr_slot;
    logic             lr_live;
    logic [TAG_W-1:0] next_lr_slot;
    logic             next_lr_live;
    // Output registers
    logic             next_ord_valid;
    logic [TAG_W-1:0] next_ord_slot;
    logic [WIN-1:0]   next_ord_wait_mask;
    logic             next_issue_ready;
    // Dependency table, lagging one cycle behind issue
    logic             dt_we;
    logic [REG_W-1:0] dt_waddr;
    logic [WIN-1:0]   dt_wdata;
    logic [WIN-1:0]   dep_a;
    logic [WIN-1:0]   dep_b;
    logic             pend;
    issue_t           pend_op;
    logic             next_pend;
    issue_t           next_pend_op;

    function automatic logic [TAG_W-1:0] first_free(input logic [WIN-1:0] b);
        logic [TAG_W-1:0] r;
        r = '0;
        for (int i = WIN - 1; i >= 0; i--) begin
            if (!b[i]) begin
                r = TAG_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic is_mem(input op_kind_t k);
        return k == OP_LOAD || k == OP_STORE || k == OP_AMO;
    endfunction

    // One issue is read from the table per two cycles, so the table
    // read data always match the op held in pend; throughput traded
    // for a registered memory with one write port.
    dep_table u_dep (
        .clk      (clk),
        .nrst     (nrst),
        .we       (dt_we),
        .waddr    (dt_waddr),
        .wdata    (dt_wdata),
        .clr_mask (perform_done),
        .raddr_a  (issue.rs1),
        .raddr_b  (issue.rs2),
        .rdata_a  (dep_a),
        .rdata_b  (dep_b)
    );

    always_comb begin
        logic [WIN-1:0]   wait_m;
        logic [WIN-1:0]   prior_ld;
        logic [WIN-1:0]   prior_st;
        logic [WIN-1:0]   rel_rcsc;
        logic [TAG_W-1:0] slot;
        logic             ld;
        logic             st;
        wait_m   = '0;
        prior_ld = '0;
        prior_st = '0;
        rel_rcsc = '0;
        slot     = first_free(busy);
        ld = pend_op.kind == OP_LOAD || pend_op.kind == OP_AMO;
        st = pend_op.kind == OP_STORE || pend_op.kind == OP_AMO;
        next_win        = win;
        next_busy       = busy & ~perform_done;
        next_acq_block  = acq_block & ~perform_done;
        next_ld_block   = ld_block & ~perform_done;
        next_st_block   = st_block & ~perform_done;
        next_ctrl_block = ctrl_block & ~perform_done;
        next_lr_slot    = lr_slot;
        next_lr_live    = lr_live && !perform_done[lr_slot];
        next_pend       = 1'b0;
        next_pend_op    = pend_op;
        next_ord_valid  = 1'b0;
        next_ord_slot   = ord_slot;
        next_ord_wait_mask = ord_wait_mask;
        dt_we    = 1'b0;
        dt_waddr = pend_op.rd;
        dt_wdata = '0;
        for (int i = 0; i < WIN; i++) begin
            prior_ld[i] = busy[i] && win[i].is_load;
            prior_st[i] = busy[i] && win[i].is_store;
            rel_rcsc[i] = busy[i] && win[i].rel && win[i].rcsc;
        end
        if (issue_valid && issue_ready) begin
            next_pend    = 1'b1;
            next_pend_op = issue;
        end
        if (pend) begin
            dt_we = 1'b1;
            case (pend_op.kind)
                OP_ALU:    dt_wdata = dep_a | dep_b;
                OP_BRANCH: begin
                    dt_we = 1'b0;
                    next_ctrl_block = next_ctrl_block
                                    | ((dep_a | dep_b) & busy);
                end
                OP_JALR:   dt_wdata = '0;
                OP_FENCE: begin
                    dt_we = 1'b0;
                    if (pend_op.fence_pr && pend_op.fence_sr
                            && pend_op.fence_sw) begin
                        next_ld_block = next_ld_block | prior_ld;
                    end
                    if (pend_op.fence_sw && !pend_op.fence_sr) begin
                        next_st_block = next_st_block
                            | (pend_op.fence_pr ? prior_ld : '0)
                            | (pend_op.fence_pw ? prior_st : '0);
                    end
                end
                OP_LOAD, OP_STORE, OP_AMO: begin
                    wait_m = acq_block | ld_block;
                    wait_m = wait_m | dep_a;
                    if (pend_op.kind != OP_LOAD) begin
                        wait_m = wait_m | dep_b;
                    end
                    if (st) begin
                        wait_m = wait_m | st_block | ctrl_block;
                    end
                    if (pend_op.rl) begin
                        wait_m = wait_m | prior_ld | prior_st;
                    end
                    if (pend_op.aq && pend_op.sc_ann) begin
                        wait_m = wait_m | rel_rcsc;
                    end
                    if (pend_op.is_sc && lr_live) begin
                        wait_m[lr_slot] = 1'b1;
                    end
                    wait_m = wait_m & busy & ~perform_done;
                    next_win[slot] = '{is_load: ld, is_store: st,
                                       acq: pend_op.aq, rel: pend_op.rl,
                                       rcsc: pend_op.sc_ann,
                                       lr: pend_op.is_lr};
                    next_busy[slot] = 1'b1;
                    // Only the annotated op blocks later ones
                    if (pend_op.aq) begin
                        next_acq_block[slot] = 1'b1;
                    end
                    if (pend_op.is_lr) begin
                        next_lr_slot = slot;
                        next_lr_live = 1'b1;
                    end
                    if (pend_op.is_sc) begin
                        next_lr_live = 1'b0;
                    end
                    dt_wdata = '0;
                    dt_wdata[slot] = ld;
                    if (pend_op.is_sc || pend_op.kind == OP_STORE) begin
                        dt_wdata[slot] = pend_op.is_sc;
                        dt_we = pend_op.is_sc;
                    end
                    next_ord_valid     = 1'b1;
                    next_ord_slot      = slot;
                    next_ord_wait_mask = wait_m;
                end
                default: dt_we = 1'b0;
            endcase
        end
        // Stall while a pending op is resolving or the window is full
        next_issue_ready = !next_pend && (next_busy != {WIN{1'b1}});
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < WIN; i++) begin
                win[i] <= '0;
            end
            busy          <= WIN_EMPTY;
            acq_block     <= WIN_EMPTY;
            ld_block      <= WIN_EMPTY;
            st_block      <= WIN_EMPTY;
            ctrl_block    <= WIN_EMPTY;
            lr_slot       <= '0;
            lr_live       <= 1'b0;
            pend          <= 1'b0;
            pend_op       <= '0;
            ord_valid     <= 1'b0;
            ord_slot      <= '0;
            ord_wait_mask <= WIN_EMPTY;
            issue_ready   <= 1'b1;
        end else begin
            win           <= next_win;
            busy          <= next_busy;
            acq_block     <= next_acq_block;
            ld_block      <= next_ld_block;
            st_block      <= next_st_block;
            ctrl_block    <= next_ctrl_block;
            lr_slot       <= next_lr_slot;
            lr_live       <= next_lr_live;
            pend          <= next_pend;
            pend_op       <= next_pend_op;
            ord_valid     <= next_ord_valid;
            ord_slot      <= next_ord_slot;
            ord_wait_mask <= next_ord_wait_mask;
            issue_ready   <= next_issue_ready;
        end
    end

    property p_rel_waits_all;
        @(posedge clk) disable iff (!nrst)
        (pend && is_mem(pend_op.kind) && pend_op.rl && perform_done == '0)
        |=> ((ord_wait_mask & $past(busy)) == $past(busy));
    endproperty
    a_rel_waits_all: assert property (p_rel_waits_all)
        else $error("release missing an earlier access");

    property p_sc_after_lr;
        @(posedge clk) disable iff (!nrst)
        (pend && pend_op.is_sc && lr_live && !perform_done[lr_slot])
        |=> ord_valid && ord_wait_mask[$past(lr_slot)];
    endproperty
    a_sc_after_lr: assert property (p_sc_after_lr)
        else $error("store-conditional not ordered after its reservation");

    property p_addr_dep;
        @(posedge clk) disable iff (!nrst)
        (pend && is_mem(pend_op.kind) && perform_done == '0)
        |=> ((ord_wait_mask & $past(dep_a)) == $past(dep_a & busy));
    endproperty
    a_addr_dep: assert property (p_addr_dep)
        else $error("address dependency dropped");

    property p_acq_blocks;
        @(posedge clk) disable iff (!nrst)
        (pend && is_mem(pend_op.kind) && perform_done == '0)
        |=> ((ord_wait_mask & $past(acq_block)) == $past(acq_block));
    endproperty
    a_acq_blocks: assert property (p_acq_blocks)
        else $error("access not ordered after acquire");

    property p_answer_one;
        @(posedge clk) disable iff (!nrst)
        ord_valid |=> !ord_valid ##1 1'b1;
    endproperty
    a_answer_one: assert property (p_answer_one)
        else $error("ordering answer lasted more than a cycle");

    // An unrelated acquire must not wait on earlier unrelated accesses
    property p_acq_only;
        @(posedge clk) disable iff (!nrst)
        (pend && is_mem(pend_op.kind) && pend_op.aq && !pend_op.rl
         && !pend_op.sc_ann && !pend_op.is_sc && dep_a == '0
         && dep_b == '0 && acq_block == '0 && ld_block == '0
         && st_block == '0 && ctrl_block == '0)
        |=> ord_wait_mask == '0;
    endproperty
    a_acq_only: assert property (p_acq_only)
        else $error("acquire held by unrelated earlier access");

    property p_load_no_st_block;
        @(posedge clk) disable iff (!nrst)
        (pend && pend_op.kind == OP_LOAD && !pend_op.rl && !pend_op.aq
         && dep_a == '0 && acq_block == '0 && ld_block == '0)
        |=> ord_wait_mask == '0;
    endproperty
    a_load_no_st_block: assert property (p_load_no_st_block)
        else $error("plain load held by store-only ordering");

    property p_ready_low_pend;
        @(posedge clk) disable iff (!nrst)
        (issue_valid && issue_ready) |=> !issue_ready;
    endproperty
    a_ready_low_pend: assert property (p_ready_low_pend)
        else $error("issue accepted while resolving previous op");

    property p_slot_busy;
        @(posedge clk) disable iff (!nrst)
        ord_valid && perform_done == '0 |-> busy[ord_slot];
    endproperty
    a_slot_busy: assert property (p_slot_busy)
        else $error("ordered op has no window slot");

endmodule

// File: verification/memory_side.sv
// Purpose: memory side model that performs window slots on request
// Assumes: a slot performs only while the enforcer shows it busy
// Notes:   go picks slots; holding go low models a slow memory system
`timescale 1ns/1ps
module memory_side
    import ordering_pkg::*;
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           nrst,
    // Control and view
    input  wire logic [WIN-1:0] go,
    input  wire logic [WIN-1:0] busy,
    // Perform pulses
    output logic      [WIN-1:0] perform_done
);
    // Masked by the last pulse so that a slot is never retired twice
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            perform_done <= WIN_EMPTY;
        end else begin
            perform_done <= busy & go & ~perform_done;
        end
    end
endmodule

// File: verification/test_hart_memory_ordering_enforcer.sv
// Purpose: self-checking bench for the memory ordering enforcer
// Assumes: ops are offered one at a time, in program order
// Notes:   slot numbers are taken from the answer, masks are predicted
`timescale 1ns/1ps
module test_hart_memory_ordering_enforcer
    import ordering_pkg::*;
;
    logic             clk;
    logic             nrst;
    logic             issue_valid;
    issue_t           issue;
    logic             issue_ready;
    logic             ord_valid;
    logic [TAG_W-1:0] ord_slot;
    logic [WIN-1:0]   ord_wait_mask;
    logic [WIN-1:0]   perform_done;
    logic [WIN-1:0]   busy;
    logic [WIN-1:0]   go;
    logic [TAG_W-1:0] s0, s1, s2, s3;
    logic [WIN-1:0]   m;
    logic [WIN-1:0]   e;
    issue_t           i;
    int               n_mismatch;
    int               checked;
    int               cycles;

    hart_memory_ordering_enforcer dut_u (
        .clk(clk), .nrst(nrst), .issue_valid(issue_valid), .issue(issue),
        .issue_ready(issue_ready), .ord_valid(ord_valid),
        .ord_slot(ord_slot), .ord_wait_mask(ord_wait_mask),
        .perform_done(perform_done), .busy(busy));
    memory_side mem_u (.clk(clk), .nrst(nrst), .go(go), .busy(busy),
        .perform_done(perform_done));

    always #10 clk = ~clk;

    function automatic issue_t op(input op_kind_t k,
        input logic [REG_W-1:0] d, input logic [REG_W-1:0] a,
        input logic [REG_W-1:0] b);
        issue_t r;
        r = '0;
        r.kind = k;
        r.rd = d;
        r.rs1 = a;
        r.rs2 = b;
        return r;
    endfunction

    function automatic logic [WIN-1:0] bit_at(input logic [TAG_W-1:0] s);
        return 8'h01 << s;
    endfunction

    task automatic chk(input string nm, input logic [WIN-1:0] x,
        input logic [WIN-1:0] g);
        checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Waits for ready, offers one op, reads the answer two edges on
    task automatic send(input issue_t t, output logic [TAG_W-1:0] s);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (issue_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        issue_valid <= 1'b1;
        issue <= t;
        @(posedge clk);
        issue_valid <= 1'b0;
        // The answer stands for one cycle only, one edge after the take
        @(posedge clk);
        #1;
        s = ord_slot;
        m = ord_wait_mask;
        if (t.kind inside {OP_LOAD, OP_STORE, OP_AMO}) begin
            chk("ord_valid", 8'h01, {7'h00, ord_valid});
        end
    endtask

    task automatic drain();
        int n;
        n = 0;
        @(posedge clk);
        go <= 8'hFF;
        @(posedge clk);
        #1;
        while (busy !== WIN_EMPTY && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("busy drained", WIN_EMPTY, busy);
        @(posedge clk);
        go <= WIN_EMPTY;
    endtask

    task automatic t_acquire();
        send(op(OP_LOAD, 5'h01, 5'h02, 5'h00), s0);
        i = op(OP_AMO, 5'h03, 5'h04, 5'h05);
        i.aq = 1'b1;
        send(i, s1);
        chk("aq amo", WIN_EMPTY, m);
        send(op(OP_STORE, 5'h00, 5'h06, 5'h07), s2);
        chk("store after aq", bit_at(s1), m);
        send(op(OP_LOAD, 5'h08, 5'h09, 5'h00), s2);
        chk("load after aq", bit_at(s1), m);
        drain();
    endtask

    task automatic t_fence_r();
        send(op(OP_LOAD, 5'h01, 5'h02, 5'h00), s0);
        send(op(OP_STORE, 5'h00, 5'h03, 5'h04), s1);
        i = op(OP_FENCE, 5'h00, 5'h00, 5'h00);
        i.fence_pr = 1'b1;
        i.fence_sr = 1'b1;
        i.fence_sw = 1'b1;
        send(i, s2);
        send(op(OP_LOAD, 5'h05, 5'h06, 5'h00), s2);
        chk("load after fence r", bit_at(s0), m);
        send(op(OP_STORE, 5'h00, 5'h07, 5'h08), s3);
        chk("store after fence r", bit_at(s0), m);
        drain();
    endtask

    task automatic t_release();
        send(op(OP_LOAD, 5'h01, 5'h02, 5'h00), s0);
        send(op(OP_STORE, 5'h00, 5'h03, 5'h04), s1);
        i = op(OP_STORE, 5'h00, 5'h05, 5'h06);
        i.rl = 1'b1;
        send(i, s2);
        chk("release store", bit_at(s0) | bit_at(s1), m);
        send(op(OP_STORE, 5'h00, 5'h07, 5'h08), s3);
        chk("store after rl", WIN_EMPTY, m);
        e = bit_at(s0) | bit_at(s1) | bit_at(s2) | bit_at(s3);
        i = op(OP_FENCE, 5'h00, 5'h00, 5'h00);
        i.fence_pr = 1'b1;
        i.fence_pw = 1'b1;
        i.fence_sw = 1'b1;
        send(i, s0);
        send(op(OP_STORE, 5'h00, 5'h09, 5'h0A), s0);
        chk("store after fence w", e, m);
        send(op(OP_LOAD, 5'h0B, 5'h0C, 5'h00), s0);
        chk("load after fence w", WIN_EMPTY, m);
        drain();
    endtask

    task automatic t_rcsc();
        i = op(OP_STORE, 5'h00, 5'h01, 5'h02);
        i.rl = 1'b1;
        send(i, s0);
        i = op(OP_LOAD, 5'h03, 5'h04, 5'h00);
        i.aq = 1'b1;
        send(i, s1);
        chk("rcpc acquire", WIN_EMPTY, m);
        i = op(OP_STORE, 5'h00, 5'h05, 5'h06);
        i.rl = 1'b1;
        i.sc_ann = 1'b1;
        send(i, s2);
        i = op(OP_LOAD, 5'h07, 5'h08, 5'h00);
        i.aq = 1'b1;
        i.sc_ann = 1'b1;
        send(i, s3);
        chk("rcsc acquire", bit_at(s1) | bit_at(s2), m);
        drain();
    endtask

    task automatic t_lrsc();
        i = op(OP_LOAD, 5'h01, 5'h02, 5'h00);
        i.is_lr = 1'b1;
        send(i, s0);
        i = op(OP_STORE, 5'h03, 5'h02, 5'h04);
        i.is_sc = 1'b1;
        send(i, s1);
        chk("sc after lr", bit_at(s0), m);
        send(op(OP_STORE, 5'h00, 5'h05, 5'h03), s2);
        chk("store on sc rd", bit_at(s1), m);
        drain();
    endtask

    task automatic t_deps();
        send(op(OP_LOAD, 5'h01, 5'h02, 5'h00), s0);
        send(op(OP_ALU, 5'h02, 5'h01, 5'h00), s1);
        send(op(OP_ALU, 5'h03, 5'h04, 5'h02), s1);
        send(op(OP_LOAD, 5'h05, 5'h03, 5'h00), s1);
        chk("address dep", bit_at(s0), m);
        send(op(OP_LOAD, 5'h06, 5'h05, 5'h00), s2);
        chk("load breaks chain", bit_at(s1), m);
        send(op(OP_JALR, 5'h07, 5'h06, 5'h00), s3);
        send(op(OP_LOAD, 5'h08, 5'h07, 5'h00), s3);
        chk("jalr link", WIN_EMPTY, m);
        drain();
    endtask

    task automatic t_data_ctrl();
        send(op(OP_LOAD, 5'h01, 5'h02, 5'h00), s0);
        send(op(OP_STORE, 5'h00, 5'h09, 5'h01), s1);
        chk("data dep", bit_at(s0), m);
        send(op(OP_LOAD, 5'h03, 5'h04, 5'h00), s1);
        send(op(OP_BRANCH, 5'h00, 5'h03, 5'h00), s2);
        send(op(OP_STORE, 5'h00, 5'h05, 5'h06), s2);
        chk("store after branch", bit_at(s1), m);
        send(op(OP_LOAD, 5'h07, 5'h08, 5'h00), s2);
        chk("load after branch", WIN_EMPTY, m);
        drain();
    endtask

    task automatic t_full();
        for (int k = 0; k < WIN; k++) begin
            send(op(OP_LOAD, 5'h01, 5'h02, 5'h00), s0);
            chk("full slot", WIN'(k), {5'h00, s0});
        end
        chk("busy full", 8'hFF, busy);
        chk("ready when full", 8'h00, {7'h00, issue_ready});
        drain();
    endtask

    task automatic complete_run();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles; the ceiling leaves margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        issue_valid = 1'b0;
        issue = '0;
        go = WIN_EMPTY;
        n_mismatch = 0;
        checked = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("ready at reset", 8'h01, {7'h00, issue_ready});
        chk("busy at reset", WIN_EMPTY, busy);
        t_acquire();
        t_fence_r();
        t_release();
        t_rcsc();
        t_lrsc();
        t_deps();
        t_data_ctrl();
        t_full();
        complete_run();
    end
endmodule
